// ### core/ipl_bank.sv
// Five priority control registers with source arbitration.
// Assumes a same-clock register master and same-clock request sources.
//
// Functional notes
// - Code seven is the most urgent level
// - Code one is least urgent enabled level
// - Code zero removes the source from arbitration
// - Bits 15, 11, 7, 3 read zero
// - Reset loads every field to level four
// - Fields read back the last written value
// - First register: timer4, compare4, compare3, dma2
// - Second: uart2 tx, uart2 rx, ext2, timer5
// - Third: can1 event, can1 rx, spi2, spi2 error
// - Fourth: capture5, capture4, capture3, dma3
// - Fifth: compare7, compare6, compare5, capture6
`timescale 1ns/1ps
module ipl_bank #(
  parameter int SRC_COUNT = ipl_pkg::SRC_COUNT
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  // Register port
  input  wire ipl_pkg::ipl_bus_req_t     bus_req,
  output      logic [ipl_pkg::DATA_W-1:0] bus_rdata,
  // Requests from the peripherals
  input  wire logic [SRC_COUNT-1:0]      src_pend,
  // Source enables and the winner
  output      logic [SRC_COUNT-1:0]      src_enabled,
  output      ipl_pkg::ipl_grant_t       grant,
  // Per-source levels
  output      ipl_pkg::ipl_level_t       timer_four_level,
  output      ipl_pkg::ipl_level_t       out_compare_four_level,
  output      ipl_pkg::ipl_level_t       out_compare_three_level,
  output      ipl_pkg::ipl_level_t       dma_chan_two_done_level,
  output      ipl_pkg::ipl_level_t       uart_two_transmit_level,
  output      ipl_pkg::ipl_level_t       uart_two_receive_level,
  output      ipl_pkg::ipl_level_t       ext_irq_two_level,
  output      ipl_pkg::ipl_level_t       timer_five_level,
  output      ipl_pkg::ipl_level_t       can_one_event_level,
  output      ipl_pkg::ipl_level_t       can_one_receive_level,
  output      ipl_pkg::ipl_level_t       spi_two_event_level,
  output      ipl_pkg::ipl_level_t       spi_two_error_level,
  output      ipl_pkg::ipl_level_t       in_capture_five_level,
  output      ipl_pkg::ipl_level_t       in_capture_four_level,
  output      ipl_pkg::ipl_level_t       in_capture_three_level,
  output      ipl_pkg::ipl_level_t       dma_chan_three_done_level,
  output      ipl_pkg::ipl_level_t       out_compare_seven_level,
  output      ipl_pkg::ipl_level_t       out_compare_six_level,
  output      ipl_pkg::ipl_level_t       out_compare_five_level,
  output      ipl_pkg::ipl_level_t       in_capture_six_level
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ipl_pkg::ipl_bank_t          bank;
    logic [ipl_pkg::DATA_W-1:0]  rdata;
  } ipl_bank_state_t;

  // Every field at level four, read data idle
  localparam ipl_bank_state_t RESET_STATE = '{
    bank:  {ipl_pkg::REG_COUNT{ipl_pkg::PRIO_RESET}},
    rdata: 16'h0000
  };

  ipl_bank_state_t st_reg;
  ipl_bank_state_t st_next;

  // ----------------------------------------------------------------
  // Internal nets
  // ----------------------------------------------------------------
  ipl_pkg::ipl_level_vec_t      levels;
  logic [SRC_COUNT-1:0]         pend_enabled;
  logic [ipl_pkg::DATA_W-1:0]   grant_word;
  logic [ipl_pkg::DATA_W-1:0]   pend_low_word;
  logic [ipl_pkg::DATA_W-1:0]   pend_high_word;
  logic [31:0]                  pend_wide;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  // One 3-bit field per source, slot 0 in the low bits
  for (genvar s = 0; s < SRC_COUNT; s++) begin : g_src
    localparam int REG_I = s / ipl_pkg::FIELD_NUM;
    localparam int LSB_I = (s % ipl_pkg::FIELD_NUM) * ipl_pkg::FIELD_STEP;
    // Codes 1 to 7 are levels 1 to 7 unchanged
    assign levels[s] = st_reg.bank[REG_I][LSB_I +: ipl_pkg::FIELD_W];
    // Zero code keeps the source away from the core
    assign src_enabled[s]  = (levels[s] != ipl_pkg::LEVEL_OFF);
    assign pend_enabled[s] = src_pend[s] & src_enabled[s];
  end

  // ----------------------------------------------------------------
  // Status words seen over the register port
  // ----------------------------------------------------------------
  // Current winner: valid, level and source number
  always_comb begin
    grant_word = 16'h0000;
    grant_word[ipl_pkg::GRANT_VALID_BIT] = grant.valid;
    grant_word[ipl_pkg::GRANT_LEVEL_LSB +: ipl_pkg::FIELD_W] = grant.level;
    grant_word[ipl_pkg::GRANT_SRC_LSB +: ipl_pkg::SRC_W] = grant.source;
  end

  // Raw pending requests, split over two words
  always_comb begin
    pend_wide = 32'h0000_0000;
    pend_wide[SRC_COUNT-1:0] = src_pend;
  end

  assign pend_low_word  = pend_wide[15:0];
  assign pend_high_word = pend_wide[31:16];

  // ----------------------------------------------------------------
  // Register write and read decode
  // ----------------------------------------------------------------
  // Writes keep only implemented bits; reads answer next cycle
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = 16'h0000;
    if (bus_req.wr) begin
      for (int i = 0; i < ipl_pkg::REG_COUNT; i++) begin
        if (bus_req.addr == (ipl_pkg::IDX_PRIO_CTRL_6 + 4'(i))) begin
          // Unimplemented bits dropped on write
          st_next.bank[i] = bus_req.wdata & ipl_pkg::IMPL_MASK;
        end
      end
    end
    if (bus_req.rd) begin
      if (bus_req.addr == ipl_pkg::IDX_PRIO_CTRL_6) begin
        st_next.rdata = st_reg.bank[0] & ipl_pkg::IMPL_MASK;
      end else if (bus_req.addr == ipl_pkg::IDX_PRIO_CTRL_7) begin
        st_next.rdata = st_reg.bank[1] & ipl_pkg::IMPL_MASK;
      end else if (bus_req.addr == ipl_pkg::IDX_PRIO_CTRL_8) begin
        st_next.rdata = st_reg.bank[2] & ipl_pkg::IMPL_MASK;
      end else if (bus_req.addr == ipl_pkg::IDX_PRIO_CTRL_9) begin
        st_next.rdata = st_reg.bank[3] & ipl_pkg::IMPL_MASK;
      end else if (bus_req.addr == ipl_pkg::IDX_PRIO_CTRL_10) begin
        st_next.rdata = st_reg.bank[4] & ipl_pkg::IMPL_MASK;
      end else if (bus_req.addr == ipl_pkg::IDX_GRANT_STAT) begin
        st_next.rdata = grant_word;
      end else if (bus_req.addr == ipl_pkg::IDX_PEND_LOW) begin
        st_next.rdata = pend_low_word;
      end else if (bus_req.addr == ipl_pkg::IDX_PEND_HIGH) begin
        st_next.rdata = pend_high_word;
      end else begin
        // Unmapped index reads as zero
        st_next.rdata = 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset puts every field at level four
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg <= RESET_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Read data stands for one cycle after the strobe
  assign bus_rdata = st_reg.rdata;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Only enabled sources reach the search
  ipl_arbiter #(
    .SRC_COUNT (SRC_COUNT)
  ) u_arbiter (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pend    (pend_enabled),
    .levels  (levels),
    .grant   (grant)
  );

  // ----------------------------------------------------------------
  // Named level outputs
  // ----------------------------------------------------------------
  // First register
  assign timer_four_level        = levels[ipl_pkg::SRC_TIMER_FOUR];
  assign out_compare_four_level  = levels[ipl_pkg::SRC_OUT_COMPARE_4];
  assign out_compare_three_level = levels[ipl_pkg::SRC_OUT_COMPARE_3];
  assign dma_chan_two_done_level = levels[ipl_pkg::SRC_DMA_CHAN_TWO];

  // Second register
  assign uart_two_transmit_level = levels[ipl_pkg::SRC_UART_TWO_TX];
  assign uart_two_receive_level  = levels[ipl_pkg::SRC_UART_TWO_RX];
  assign ext_irq_two_level       = levels[ipl_pkg::SRC_EXT_IRQ_TWO];
  assign timer_five_level        = levels[ipl_pkg::SRC_TIMER_FIVE];

  // Third register
  assign can_one_event_level     = levels[ipl_pkg::SRC_CAN_ONE_EVENT];
  assign can_one_receive_level   = levels[ipl_pkg::SRC_CAN_ONE_RX];
  assign spi_two_event_level     = levels[ipl_pkg::SRC_SPI_TWO_EVENT];
  assign spi_two_error_level     = levels[ipl_pkg::SRC_SPI_TWO_ERROR];

  // Fourth register
  assign in_capture_five_level     = levels[ipl_pkg::SRC_IN_CAPTURE_5];
  assign in_capture_four_level     = levels[ipl_pkg::SRC_IN_CAPTURE_4];
  assign in_capture_three_level    = levels[ipl_pkg::SRC_IN_CAPTURE_3];
  assign dma_chan_three_done_level = levels[ipl_pkg::SRC_DMA_CHAN_THREE];

  // Fifth register
  assign out_compare_seven_level = levels[ipl_pkg::SRC_OUT_COMPARE_7];
  assign out_compare_six_level   = levels[ipl_pkg::SRC_OUT_COMPARE_6];
  assign out_compare_five_level  = levels[ipl_pkg::SRC_OUT_COMPARE_5];
  assign in_capture_six_level    = levels[ipl_pkg::SRC_IN_CAPTURE_6];

endmodule // ipl_bank

// ### core/ipl_pkg.sv
// Constants, field layout and carriers for the priority level bank.
// Assumes one clock domain and a synchronous, active-high reset.
package ipl_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int REG_COUNT  = 5;
  localparam int FIELD_NUM  = 4;
  localparam int SRC_COUNT  = REG_COUNT * FIELD_NUM;
  localparam int FIELD_W    = 3;
  localparam int FIELD_STEP = 4;
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 4;
  localparam int SRC_W      = 5;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_PRIO_CTRL_6  = 4'h0;
  localparam logic [3:0] IDX_PRIO_CTRL_7  = 4'h1;
  localparam logic [3:0] IDX_PRIO_CTRL_8  = 4'h2;
  localparam logic [3:0] IDX_PRIO_CTRL_9  = 4'h3;
  localparam logic [3:0] IDX_PRIO_CTRL_10 = 4'h4;
  localparam logic [3:0] IDX_GRANT_STAT   = 4'h5;
  localparam logic [3:0] IDX_PEND_LOW     = 4'h6;
  localparam logic [3:0] IDX_PEND_HIGH    = 4'h7;

  // ----------------------------------------------------------------
  // Field layout, reset values and level codes
  // ----------------------------------------------------------------
  localparam logic [15:0] IMPL_MASK     = 16'h7777;
  localparam logic [15:0] PRIO_RESET    = 16'h4444;
  localparam logic [2:0]  LEVEL_OFF     = 3'h0;
  localparam logic [2:0]  LEVEL_LOWEST  = 3'h1;
  localparam logic [2:0]  LEVEL_HIGHEST = 3'h7;
  localparam int          GRANT_VALID_BIT = 15;
  localparam int          GRANT_LEVEL_LSB = 8;
  localparam int          GRANT_SRC_LSB   = 0;

  // ----------------------------------------------------------------
  // Source numbers: register index times four plus field slot
  // ----------------------------------------------------------------
  localparam int SRC_DMA_CHAN_TWO     = 0;
  localparam int SRC_OUT_COMPARE_3    = 1;
  localparam int SRC_OUT_COMPARE_4    = 2;
  localparam int SRC_TIMER_FOUR       = 3;
  localparam int SRC_TIMER_FIVE       = 4;
  localparam int SRC_EXT_IRQ_TWO      = 5;
  localparam int SRC_UART_TWO_RX      = 6;
  localparam int SRC_UART_TWO_TX      = 7;
  localparam int SRC_SPI_TWO_ERROR    = 8;
  localparam int SRC_SPI_TWO_EVENT    = 9;
  localparam int SRC_CAN_ONE_RX       = 10;
  localparam int SRC_CAN_ONE_EVENT    = 11;
  localparam int SRC_DMA_CHAN_THREE   = 12;
  localparam int SRC_IN_CAPTURE_3     = 13;
  localparam int SRC_IN_CAPTURE_4     = 14;
  localparam int SRC_IN_CAPTURE_5     = 15;
  localparam int SRC_IN_CAPTURE_6     = 16;
  localparam int SRC_OUT_COMPARE_5    = 17;
  localparam int SRC_OUT_COMPARE_6    = 18;
  localparam int SRC_OUT_COMPARE_7    = 19;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [2:0] ipl_level_t;
  typedef ipl_level_t [SRC_COUNT-1:0] ipl_level_vec_t;
  typedef logic [REG_COUNT-1:0][DATA_W-1:0] ipl_bank_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ipl_bus_req_t;

  typedef struct packed {
    logic             valid;
    logic [SRC_W-1:0] source;
    ipl_level_t       level;
  } ipl_grant_t;

endpackage

// ### core/ipl_arbiter.sv
// Picks the most urgent pending, enabled source each cycle.
// Assumes requests and levels come from logic on the same clock.
`timescale 1ns/1ps
module ipl_arbiter #(
  parameter int SRC_COUNT = ipl_pkg::SRC_COUNT
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  // Source side
  input  wire logic [SRC_COUNT-1:0]   pend,
  input  wire ipl_pkg::ipl_level_vec_t levels,
  // Winner
  output      ipl_pkg::ipl_grant_t    grant
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ipl_pkg::ipl_grant_t grant;
  } ipl_arb_state_t;

  ipl_arb_state_t st_reg;
  ipl_arb_state_t st_next;

  // ----------------------------------------------------------------
  // Search
  // ----------------------------------------------------------------
  // Highest level wins; lowest source number breaks a tie
  always_comb begin
    ipl_pkg::ipl_level_t best_level;
    logic [ipl_pkg::SRC_W-1:0] best_src;
    best_level = ipl_pkg::LEVEL_OFF;
    best_src   = '0;
    for (int s = 0; s < SRC_COUNT; s++) begin
      if (pend[s] && (levels[s] > best_level)) begin
        best_level = levels[s];
        best_src   = ipl_pkg::SRC_W'(s);
      end
    end
    st_next              = st_reg;
    st_next.grant.valid  = (best_level != ipl_pkg::LEVEL_OFF);
    st_next.grant.source = best_src;
    st_next.grant.level  = best_level;
  end

  // Register the winner
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign grant = st_reg.grant;

endmodule // ipl_arbiter

// ### sim/ipl_bank_props.sv
// Port checker for the priority level bank.
// Assumes a bind onto ipl_bank, one clock and a synchronous reset.
`timescale 1ns/1ps
module ipl_bank_props #(
  parameter int SRC_COUNT = ipl_pkg::SRC_COUNT
) (
  // Clock and reset
  input wire logic                   clock,
  input wire logic                   sys_rst,
  // Watched ports
  input wire ipl_pkg::ipl_bus_req_t  bus_req,
  input wire logic [15:0]            bus_rdata,
  input wire logic [SRC_COUNT-1:0]   src_pend,
  input wire logic [SRC_COUNT-1:0]   src_enabled,
  input wire ipl_pkg::ipl_grant_t    grant,
  input wire ipl_pkg::ipl_level_t    timer_four_level,
  input wire ipl_pkg::ipl_level_t    in_capture_six_level
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_rd_unused: assert property ($past(bus_req.rd) && $past(bus_req.addr) < 4'h5
    |-> (bus_rdata & 16'h8888) == 16'h0000) else $error("unused bit read nonzero");
  chk_rd_back: assert property (bus_req.rd && bus_req.addr == 4'h4
    |=> bus_rdata[2:0] == $past(in_capture_six_level)) else $error("read back wrong");
  chk_wr_field: assert property (bus_req.wr && bus_req.addr == 4'h0
    |=> timer_four_level == $past(bus_req.wdata[14:12])) else $error("field placement");
  chk_reset_level: assert property ($past(sys_rst)
    |-> timer_four_level == 3'h4 && in_capture_six_level == 3'h4) else $error("reset level");
  chk_off_map: assert property (src_enabled[3] == (timer_four_level != 3'h0))
    else $error("enable map wrong");
  chk_none_idle: assert property ((src_pend & src_enabled) == '0 |=> !grant.valid)
    else $error("grant without request");
  chk_grant_src: assert property (grant.valid
    |-> (($past(src_pend & src_enabled) >> grant.source) & 1) != 0) else $error("bad winner");
  chk_top_level: assert property (src_pend[3] && timer_four_level == 3'h7
    |=> grant.valid && grant.level == 3'h7) else $error("level seven lost");
  chk_low_level: assert property ((src_pend & src_enabled) == 20'h1_0000
    && in_capture_six_level == 3'h1 |=> grant.source == 5'h10 && grant.level == 3'h1)
    else $error("level one grant wrong");

  cover property (bus_req.wr ##1 bus_req.rd);
  cover property (grant.valid && grant.level == 3'h7);
  cover property (src_pend != '0 ##1 !grant.valid);
endmodule // ipl_bank_props

bind ipl_bank ipl_bank_props #(.SRC_COUNT(SRC_COUNT)) u_props (
  .clock(clock), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .src_pend(src_pend), .src_enabled(src_enabled), .grant(grant),
  .timer_four_level(timer_four_level), .in_capture_six_level(in_capture_six_level));

// ### sim/ipl_src_model.sv
// Peripheral request sources facing the bank.
// Assumes the bench sets the wanted pattern on the bank's clock.
`timescale 1ns/1ps
module ipl_src_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Wanted pattern and driven requests
  input  wire logic [19:0] want,
  output logic      [19:0] src_pend
);
  // Requests follow one edge later and hold as levels
  always_ff @(posedge clock) begin
    if (sys_rst) src_pend <= '0;
    else src_pend <= want;
  end
endmodule // ipl_src_model

// ### sim/ipl_bank_test.sv
// Self-checking bench for the priority level bank.
// Assumes the package, the design and the source model compile first.
`timescale 1ns/1ps
module ipl_bank_test;
  logic                  clock = 1'b0;
  logic                  sys_rst = 1'b1;
  ipl_pkg::ipl_bus_req_t bus_req = '0;
  logic [19:0]           want = '0;
  logic [19:0]           src_pend;
  logic [19:0]           src_enabled;
  logic [15:0]           bus_rdata;
  ipl_pkg::ipl_grant_t   grant;
  wire  [59:0]           lv;
  int                    err_count = 0;
  int                    checks_done = 0;
  int                    regs [5];
  logic [31:0]           rnd = 32'h0000_3702;

  // Clock at 200 MHz
  always #2.5 clock = ~clock;

  ipl_src_model srcs (.clock(clock), .sys_rst(sys_rst), .want(want), .src_pend(src_pend));

  ipl_bank dut (
    .clock(clock), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .src_pend(src_pend), .src_enabled(src_enabled), .grant(grant),
    .dma_chan_two_done_level(lv[2:0]), .out_compare_three_level(lv[5:3]),
    .out_compare_four_level(lv[8:6]), .timer_four_level(lv[11:9]),
    .timer_five_level(lv[14:12]), .ext_irq_two_level(lv[17:15]),
    .uart_two_receive_level(lv[20:18]), .uart_two_transmit_level(lv[23:21]),
    .spi_two_error_level(lv[26:24]), .spi_two_event_level(lv[29:27]),
    .can_one_receive_level(lv[32:30]), .can_one_event_level(lv[35:33]),
    .dma_chan_three_done_level(lv[38:36]), .in_capture_three_level(lv[41:39]),
    .in_capture_four_level(lv[44:42]), .in_capture_five_level(lv[47:45]),
    .in_capture_six_level(lv[50:48]), .out_compare_five_level(lv[53:51]),
    .out_compare_six_level(lv[56:54]), .out_compare_seven_level(lv[59:57]));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [59:0] seen, input logic [59:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Level views and enables against the register model
  task automatic chk_view;
    logic [59:0] e;
    logic [19:0] en;
    for (int s = 0; s < 20; s++) begin
      e[3*s+:3] = 3'((regs[s/4] >> (4 * (s % 4))) & 7);
      en[s] = e[3*s+:3] != 3'h0;
    end
    chk(lv, e);
    chk(60'(src_enabled), 60'(en));
  endtask

  // Highest level wins, lowest source on a tie, level zero never
  function automatic logic [8:0] exp_grant();
    int best;
    int lvl;
    best = -1;
    lvl = 0;
    for (int s = 0; s < 20; s++) begin
      if (want[s] && ((regs[s/4] >> (4 * (s % 4))) & 7) > lvl) begin
        best = s;
        lvl = (regs[s/4] >> (4 * (s % 4))) & 7;
      end
    end
    return (best < 0) ? 9'h000 : {1'b1, 5'(best), 3'(lvl)};
  endfunction

  // Expected read word for any index, status words included
  function automatic logic [15:0] rd_exp(input logic [3:0] a);
    logic [15:0] w;
    logic [8:0]  g;
    w = 16'h0000;
    g = exp_grant();
    if (a < 4'h5) begin
      w = 16'(regs[a]);
    end else if (a == 4'h5) begin
      w[ipl_pkg::GRANT_VALID_BIT] = g[8];
      w[ipl_pkg::GRANT_LEVEL_LSB +: 3] = g[2:0];
      w[ipl_pkg::GRANT_SRC_LSB +: 5] = g[7:3];
    end else if (a == 4'h6) begin
      w = want[15:0];
    end else if (a == 4'h7) begin
      w = {12'h000, want[19:16]};
    end
    return w;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge clock);
    bus_req.wr <= 1'b0;
    if (a < 5) regs[a] = d & 16'h7777;
    #1 chk_view();
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 chk(60'(bus_rdata), 60'(rd_exp(a)));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 5; i++) regs[i] = 16'h4444;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    #1 chk_view();
    for (int a = 0; a < 5; a++) rd(4'(a));
    $display("reset test done");
    for (int i = 0; i < 30; i++) begin
      rnd = lfsr(rnd);
      wr(4'(rnd % 5), rnd[15:0]);
      rd(4'(rnd % 5));
    end
    wr(4'h9, 16'hFFFF);
    for (int a = 0; a < 5; a++) rd(4'(a));
    rd(4'h9);
    $display("register test done");
    // Reset again mid-run: every field back to level four
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) regs[i] = 16'h4444;
    #1 chk_view();
    for (int a = 0; a < 5; a++) rd(4'(a));
    $display("second reset test done");
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      case (i)
        0: wr(4'h0, 16'h7004);
        1: wr(4'h4, 16'h0001);
        2: wr(4'h0, 16'h0004);
        default: wr(4'(rnd % 5), rnd[15:0]);
      endcase
      @(posedge clock);
      want <= (i == 0) ? 20'h0_0009 : (i == 1) ? 20'h1_0000 :
              (i == 2) ? 20'h0_0008 : rnd[31:12];
      repeat (3) @(posedge clock);
      #1 chk(60'(grant), 60'(exp_grant()));
      rd(4'h5);
      rd(4'h6);
      rd(4'h7);
    end
    $display("arbitration test done");
    end_sim();
  end

  // Watchdog far beyond the expected run length
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
endmodule // ipl_bank_test
